// >>> hdl/csh_pkg.sv
package csh_pkg;
    // byte addresses on apb: printed offsets are not all multiples of four,
    // so each printed offset is a register index and the address is index*4
    localparam logic [15:0] CSH_IDX_STATUS = 16'h00d7;
    localparam logic [15:0] CSH_IDX_SAMPCTL = 16'h00dc;
    localparam logic [15:0] CSH_IDX_SWITCH = 16'h00e1;
    localparam logic [15:0] CSH_IDX_HALL = 16'h00e2;
    localparam logic [15:0] CSH_IDX_DELAY = 16'h40ad;
    localparam logic [17:0] CSH_ADR_STATUS = {CSH_IDX_STATUS, 2'b00};
    localparam logic [17:0] CSH_ADR_SAMPCTL = {CSH_IDX_SAMPCTL, 2'b00};
    localparam logic [17:0] CSH_ADR_SWITCH = {CSH_IDX_SWITCH, 2'b00};
    localparam logic [17:0] CSH_ADR_HALL = {CSH_IDX_HALL, 2'b00};
    localparam logic [17:0] CSH_ADR_DELAY = {CSH_IDX_DELAY, 2'b00};
    // own registers for the interrupt status and mask
    localparam logic [17:0] CSH_ADR_EVT_STAT = 18'h20000;
    localparam logic [17:0] CSH_ADR_EVT_MASK = 18'h20004;

    // reset values
    localparam logic [7:0] CSH_RST_SAMPCTL = 8'h00;
    localparam logic [7:0] CSH_RST_DELAY = 8'h01;
    localparam logic [7:0] CSH_RST_SWITCH = 8'h00;
    localparam logic [7:0] CSH_RST_HALL = 8'h00;
    localparam logic [4:0] CSH_RST_MASK = 5'h00;

    // field positions
    localparam int CSH_B_DTEN = 7;
    localparam int CSH_B_DBG_LO = 5;
    localparam int CSH_B_SAM_LO = 3;
    localparam int CSH_B_BUSSW = 4;
    localparam int CSH_B_C5HYS = 3;
    localparam int CSH_B_SCALE = 2;
    localparam int CSH_B_FSW = 1;
    localparam int CSH_B_C5EN = 0;
    localparam int CSH_B_HIF = 7;
    localparam int CSH_B_HIE = 6;
    localparam int CSH_B_HSEL = 3;

    // delay base counts in clock periods
    localparam logic [5:0] CSH_BASE_NORM = 6'h08;
    localparam logic [5:0] CSH_BASE_SCALED = 6'h20;
    localparam logic [1:0] CSH_MODE_RESISTOR = 2'b01;

    typedef enum logic [1:0] {CSH_SAM_BOTH_NODLY, CSH_SAM_OFF, CSH_SAM_ON, CSH_SAM_BOTH}
        csh_sam_t;
    typedef enum logic [1:0] {CSH_DBG_OFF, CSH_DBG_ZCP, CSH_DBG_ADC, CSH_DBG_WIN} csh_dbg_t;

    // sampling control register layout
    typedef struct packed {
        logic dt_en;
        csh_dbg_t debug_pin_select;
        csh_sam_t sampling_mode_select;
        logic [2:0] compare_output_select;
    } csh_sampctl_t;

    // analog side inputs
    typedef struct packed {
        logic [5:0] comp;
        logic angle_flag;
        logic zero_crossing_point;
        logic adc_trigger;
    } csh_analog_t;
endpackage

// >>> hdl/csh_core.sv
// Overview of operation
// - debug pin selects zcp, adc trigger, window
// - mode 00 samples both phases, no delay
// - 01 off phase, 10 on phase, delayed
// - mode 11 both phases with delays
// - output selector routes comparator to pin
// - bus switch reroutes comp3/comp4 shared pin
// - scale-up multiplies delay base by four
// - function switch only in input mode 01
// - on-delay is 8 or 32 times field
// - off-lead ends window early likewise
// - comparator flags cleared by writing zero
// - hall flag set on hall edge
// - mode 01 alone lets switch alter inputs
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module csh_core
    import csh_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // analog and timer side
    input wire csh_analog_t i_analog,
    input wire logic [3:0] i_comp_event,
    input wire logic i_pwm_on,
    input wire logic [1:0] i_comparator_input_mode,
    input wire logic [2:0] i_hall_grp0,
    input wire logic [2:0] i_hall_grp1,
    // pins and routing controls
    output logic o_debug_pin,
    output logic o_cmp_out_pin,
    output logic o_cmp_out_to_debug,
    output logic o_sample_window,
    output logic o_bus_current_switch,
    output logic o_comp3_single_input,
    output logic o_comp12_function_switch,
    output logic o_comp5_hysteresis,
    output logic o_comp5_enable,
    output logic o_scale_up_enable,
    output logic o_hall_irq,
    output logic o_irq
);
    csh_sampctl_t ctl_r;
    logic [7:0] delay_r;
    logic [4:0] sw_r;
    logic hie_r, hsel_r, hif_r;
    logic [3:0] cif_r;
    logic [4:0] evt_r, mask_r;
    logic [2:0] hall_r, hall_prev_r;
    logic [5:0] comp_r;
    logic pwm_prev_r, win_r;
    logic [9:0] cnt_r;
    logic [31:0] rdata_r;

    // bus decode; access completes in its first access cycle
    wire wr = i_psel && i_penable && i_pwrite;
    wire rd = i_psel && i_penable && !i_pwrite;
    // read data captured in setup so it already stands at the access edge
    wire rd_setup = i_psel && !i_penable && !i_pwrite;
    wire hit_stat = i_paddr == CSH_ADR_STATUS;
    wire hit_ctl = i_paddr == CSH_ADR_SAMPCTL;
    wire hit_sw = i_paddr == CSH_ADR_SWITCH;
    wire hit_hall = i_paddr == CSH_ADR_HALL;
    wire hit_dly = i_paddr == CSH_ADR_DELAY;
    wire hit_es = i_paddr == CSH_ADR_EVT_STAT;
    wire hit_em = i_paddr == CSH_ADR_EVT_MASK;
    wire hit_any = hit_stat | hit_ctl | hit_sw | hit_hall | hit_dly | hit_es | hit_em;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit_any;
    assign o_prdata = rdata_r;

    // hall input: selected group, edge against previous clock
    wire [2:0] hall_in = hsel_r ? i_hall_grp1 : i_hall_grp0;
    wire hall_edge = hall_r != hall_prev_r;

    // sampling window timing, delay unit 8 or 32 clocks
    wire [5:0] base = sw_r[CSH_B_SCALE] ? CSH_BASE_SCALED : CSH_BASE_NORM;
    // operands widened first: a 6-bit product would wrap above 63 clocks
    wire [9:0] on_dly = 10'(base) * 10'(delay_r[7:4]);
    wire [9:0] off_lead = 10'(base) * 10'(delay_r[3:0]);
    wire pwm_edge = i_pwm_on != pwm_prev_r;
    wire phase_ok = (ctl_r.sampling_mode_select == CSH_SAM_BOTH_NODLY) ||
                    (ctl_r.sampling_mode_select == CSH_SAM_BOTH) ||
                    (ctl_r.sampling_mode_select == CSH_SAM_OFF && !i_pwm_on) ||
                    (ctl_r.sampling_mode_select == CSH_SAM_ON && i_pwm_on);
    wire no_dly = ctl_r.sampling_mode_select == CSH_SAM_BOTH_NODLY;
    // window opens after on-delay, closes on-delay minus off-lead later
    wire [9:0] close_at = on_dly + (on_dly - off_lead);
    wire win_nxt = phase_ok && (no_dly || (cnt_r >= on_dly && cnt_r < close_at));
    assign o_sample_window = win_r;

    // pin muxes
    wire [7:0] cmp_src = {i_analog.angle_flag, comp_r, 1'b0};
    assign o_cmp_out_pin = cmp_src[ctl_r.compare_output_select];
    assign o_cmp_out_to_debug = ctl_r.debug_pin_select == CSH_DBG_OFF &&
                                ctl_r.compare_output_select != 3'b000;
    logic dbg;
    always_comb begin
        unique case (ctl_r.debug_pin_select)
            CSH_DBG_OFF: dbg = o_cmp_out_to_debug ? o_cmp_out_pin : 1'b0;
            CSH_DBG_ZCP: dbg = i_analog.zero_crossing_point;
            CSH_DBG_ADC: dbg = i_analog.adc_trigger;
            CSH_DBG_WIN: dbg = win_r;
        endcase
    end
    assign o_debug_pin = dbg;

    // routing controls
    assign o_bus_current_switch = sw_r[CSH_B_BUSSW];
    assign o_comp3_single_input = sw_r[CSH_B_BUSSW];
    assign o_comp12_function_switch = sw_r[CSH_B_FSW] &&
        i_comparator_input_mode == CSH_MODE_RESISTOR;
    assign o_comp5_hysteresis = sw_r[CSH_B_C5HYS];
    assign o_comp5_enable = sw_r[CSH_B_C5EN];
    assign o_scale_up_enable = sw_r[CSH_B_SCALE];
    assign o_hall_irq = hif_r && hie_r;
    assign o_irq = |(evt_r & mask_r);

    // read mux; results are live synchronised levels
    logic [7:0] rmux;
    always_comb begin
        rmux = 8'h00;
        if (hit_stat) rmux = {cif_r, comp_r[3:0]};
        if (hit_ctl) rmux = ctl_r;
        if (hit_sw) rmux = {comp_r[4], comp_r[5], 1'b0, sw_r};
        if (hit_hall) rmux = {hif_r, hie_r, 2'b00, hsel_r, hall_r};
        if (hit_dly) rmux = delay_r;
        if (hit_es) rmux = {3'b000, evt_r};
        if (hit_em) rmux = {3'b000, mask_r};
    end

    // write-zero clears; a same-cycle set wins
    wire [3:0] cif_clr = (wr && hit_stat) ? ~i_pwdata[7:4] : 4'h0;
    wire hif_clr = wr && hit_hall && !i_pwdata[CSH_B_HIF];
    wire [4:0] evt_set = {hall_edge, i_comp_event};

    // inputs and sample state
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hall_r <= 3'h0;
            hall_prev_r <= 3'h0;
            comp_r <= 6'h00;
            pwm_prev_r <= 1'b0;
            win_r <= 1'b0;
            cnt_r <= 10'h000;
        end else begin
            hall_r <= hall_in;
            hall_prev_r <= hall_r;
            comp_r <= i_analog.comp;
            pwm_prev_r <= i_pwm_on;
            win_r <= win_nxt;
            cnt_r <= pwm_edge ? 10'h000 : (&cnt_r ? cnt_r : cnt_r + 10'h001);
        end
    end

    // registers and flags
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctl_r <= CSH_RST_SAMPCTL;
            delay_r <= CSH_RST_DELAY;
            sw_r <= CSH_RST_SWITCH[4:0];
            hie_r <= 1'b0;
            hsel_r <= 1'b0;
            hif_r <= 1'b0;
            cif_r <= 4'h0;
            evt_r <= 5'h00;
            mask_r <= CSH_RST_MASK;
            rdata_r <= 32'h0;
        end else begin
            if (wr && hit_ctl) ctl_r <= i_pwdata[7:0];
            if (wr && hit_dly) delay_r <= i_pwdata[7:0];
            if (wr && hit_sw) sw_r <= i_pwdata[4:0];
            if (wr && hit_hall) begin
                hie_r <= i_pwdata[CSH_B_HIE];
                hsel_r <= i_pwdata[CSH_B_HSEL];
            end
            if (wr && hit_em) mask_r <= i_pwdata[4:0];
            cif_r <= (cif_r & ~cif_clr) | i_comp_event;
            hif_r <= (hif_r & ~hif_clr) | hall_edge;
            // read clears only the bits returned, so a later event survives
            evt_r <= (rd && hit_es) ? ((evt_r & ~rdata_r[4:0]) | evt_set) : (evt_r | evt_set);
            if (rd_setup) rdata_r <= {24'h0, rmux};
        end
    end

    // checks
    a_flag_set_wins: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        hall_edge |=> hif_r) else $error("hall flag missed edge");
    a_hall_irq_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_hall_irq == (hif_r && hie_r)) else $error("hall irq wrong");
    a_cmp_flag_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (wr && hit_stat && !i_pwdata[4] && !i_comp_event[0]) |=> !cif_r[0])
        else $error("flag not cleared");
    a_cmp_flag_keep: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (cif_r[0] && !(wr && hit_stat && !i_pwdata[4])) |=> cif_r[0])
        else $error("flag lost");
    a_mode0_window: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.sampling_mode_select == CSH_SAM_BOTH_NODLY) |=> win_r)
        else $error("mode 0 window closed");
    // multi-step behaviour expressed through named sequences
    sequence s_pwm_turn;
        pwm_edge && !no_dly && delay_r[7:4] != 4'h0;
    endsequence

    sequence s_hall_change;
        hall_in != $past(hall_in);
    endsequence

    a_ondelay_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_pwm_turn |=> !win_r)
        else $error("window opened early");

    // phase gating of the window
    a_off_phase_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.sampling_mode_select == CSH_SAM_OFF && i_pwm_on) |=> !win_r)
        else $error("off mode sampled in on phase");

    a_on_phase_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.sampling_mode_select == CSH_SAM_ON && !i_pwm_on) |=> !win_r)
        else $error("on mode sampled in off phase");

    a_window_closes: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!no_dly && cnt_r >= close_at) |=> !win_r)
        else $error("window past off lead");

    // delay arithmetic against the field times the base unit
    a_ondelay_norm: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !sw_r[CSH_B_SCALE] |-> on_dly == {3'b000, delay_r[7:4], 3'b000})
        else $error("on delay not 8 units");

    a_ondelay_scaled: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sw_r[CSH_B_SCALE] |-> on_dly == {1'b0, delay_r[7:4], 5'h00})
        else $error("on delay not 32 units");

    a_offlead_scaled: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        sw_r[CSH_B_SCALE] |-> off_lead == {1'b0, delay_r[3:0], 5'h00})
        else $error("off lead not 32 units");

    // debug and compare pin routing
    a_debug_zcp: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.debug_pin_select == CSH_DBG_ZCP) |->
        o_debug_pin == i_analog.zero_crossing_point)
        else $error("debug zcp wrong");

    a_debug_win: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.debug_pin_select == CSH_DBG_WIN) |-> o_debug_pin == win_r)
        else $error("debug window wrong");

    a_debug_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.debug_pin_select == CSH_DBG_OFF && ctl_r.compare_output_select == 3'b000)
        |-> !o_debug_pin)
        else $error("debug pin not idle");

    a_cmp_pin_none: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.compare_output_select == 3'b000) |-> !o_cmp_out_pin)
        else $error("compare pin not idle");

    a_cmp_pin_angle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.compare_output_select == 3'b111) |-> o_cmp_out_pin == i_analog.angle_flag)
        else $error("compare pin angle wrong");

    a_fsw_on: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_comparator_input_mode == CSH_MODE_RESISTOR && sw_r[CSH_B_FSW])
        |-> o_comp12_function_switch)
        else $error("switch lost in mode 01");

    // flags and live results
    a_cmp_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_comp_event[1] |=> cif_r[1])
        else $error("comparator flag missed");

    a_hall_flag_clr: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (hif_clr && !hall_edge) |=> !hif_r)
        else $error("hall flag not cleared");

    a_hall_irq_after: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (hie_r && hall_edge && !(wr && hit_hall)) |=> o_hall_irq)
        else $error("hall irq missed");

    a_live_result: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (rd_setup && hit_stat) |=> rdata_r[3:0] == $past(comp_r[3:0]))
        else $error("result bits stale");

    a_fsw_gate: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_comparator_input_mode != CSH_MODE_RESISTOR) |-> !o_comp12_function_switch)
        else $error("switch outside mode 01");
    a_debug_adc: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (ctl_r.debug_pin_select == CSH_DBG_ADC) |-> o_debug_pin == i_analog.adc_trigger)
        else $error("debug mux wrong");
    a_hall_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_hall_change |=> ##1 hif_r) else $error("hall edge lost");
endmodule
`default_nettype wire

// >>> dv/csh_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// pwm phase source and comparator levels seen by the block
module csh_analog_model
    import csh_pkg::*;
#(
    parameter int HALF = 80
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // levels chosen by the bench
    input wire logic [8:0] i_levels,
    // to the block
    output csh_analog_t o_analog,
    output logic o_pwm_on
);
    int cnt;
    // free running phase, long enough to hold the scaled delays
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 0;
            o_pwm_on <= 1'b0;
        end else begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            o_pwm_on <= o_pwm_on ^ (cnt == HALF - 1);
        end
    end
    assign o_analog = i_levels;
endmodule
`default_nettype wire

// >>> dv/csh_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module csh_core_tb
    import csh_pkg::*;
;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [17:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata, rd, seed = 32'h9d9c5770;
    logic o_pready, o_pslverr, err, i_pwm_on;
    csh_analog_t i_analog;
    logic [8:0] levels = '0;
    logic [3:0] i_comp_event = '0;
    logic [1:0] i_comparator_input_mode = '0;
    logic [2:0] i_hall_grp0 = '0, i_hall_grp1 = '0;
    logic o_debug_pin, o_cmp_out_pin, o_cmp_out_to_debug, o_sample_window, o_irq;
    logic o_bus_current_switch, o_comp3_single_input, o_comp12_function_switch;
    logic o_comp5_hysteresis, o_comp5_enable, o_scale_up_enable, o_hall_irq;
    int n_errors = 0, n_checks = 0;

    // 40 mhz clock
    always #12.5 i_sys_clk = ~i_sys_clk;

    csh_analog_model i_csh_analog_model (.i_sys_clk, .i_rst, .i_levels(levels),
        .o_analog(i_analog), .o_pwm_on(i_pwm_on));
    csh_core i_csh_core (.i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_analog, .i_comp_event, .i_pwm_on,
        .i_comparator_input_mode, .i_hall_grp0, .i_hall_grp1, .o_debug_pin, .o_cmp_out_pin,
        .o_cmp_out_to_debug, .o_sample_window, .o_bus_current_switch, .o_comp3_single_input,
        .o_comp12_function_switch, .o_comp5_hysteresis, .o_comp5_enable, .o_scale_up_enable,
        .o_hall_irq, .o_irq);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected compare pin: none, comparators 0..5, angle flag
    function automatic logic exp_cmp(input int k, input logic [8:0] lv);
        return (k == 0) ? 1'b0 : (k == 7) ? lv[2] : lv[k + 2];
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // apb transfer; read data taken at the edge where pready is seen high
    task automatic apb(input logic [17:0] a, input logic w, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
            err = o_pslverr;
            rd = o_prdata;
        end while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        // later checks look at settled outputs mid-cycle
        @(negedge i_sys_clk);
    endtask

    // window probed away from its edges, timed from a pwm phase change
    task automatic win(input logic [1:0] m, input logic [7:0] d, input logic s, input logic t);
        int on, cl;
        logic ok;
        on = (s ? 32 : 8) * d[7:4];
        cl = 2 * on - (s ? 32 : 8) * d[3:0];
        ok = (m == 2'b11) || (m == 2'b01 && !t) || (m == 2'b10 && t) || (m == 2'b00);
        apb(CSH_ADR_SWITCH, 1'b1, {29'h0, s, 2'b00});
        apb(CSH_ADR_DELAY, 1'b1, {24'h0, d});
        apb(CSH_ADR_SAMPCTL, 1'b1, {24'h0, 3'b011, m, 3'h0});
        while (i_pwm_on !== !t)
            @(negedge i_sys_clk);
        while (i_pwm_on !== t)
            @(negedge i_sys_clk);
        for (int i = 1; i <= cl + 4; i++) begin
            @(negedge i_sys_clk);
            if (i == on - 4 || i == cl + 4)
                chk(32'(o_sample_window), 32'(m == 2'b00));
            if (i == (on + cl) / 2)
                chk(32'(o_sample_window), 32'(ok));
        end
    endtask

    // hang guard, far beyond the fewer than two thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_errors++;
        conclude();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        apb(CSH_ADR_SAMPCTL, 1'b0, 0);
        chk(rd, {24'h0, CSH_RST_SAMPCTL});
        apb(CSH_ADR_DELAY, 1'b0, 0);
        chk(rd, 32'h01);
        apb(18'h00100, 1'b1, 32'hff);
        chk({31'h0, err}, 32'h1);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            apb(CSH_ADR_SAMPCTL, 1'b1, {24'h0, seed[7:0]});
            apb(CSH_ADR_SAMPCTL, 1'b0, 0);
            chk(rd, {24'h0, seed[7:0]});
        end
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            @(posedge i_sys_clk) levels <= seed[8:0];
            apb(CSH_ADR_SAMPCTL, 1'b1, {29'h0, 3'(k)});
            chk(32'(o_cmp_out_pin), 32'(exp_cmp(k, levels)));
            chk(32'(o_cmp_out_to_debug), 32'(k != 0));
        end
        for (int k = 0; k < 4; k++) begin
            apb(CSH_ADR_SAMPCTL, 1'b1, {25'h0, 2'(k), 5'h0});
            chk(32'(o_debug_pin), 32'(k == 0 ? 1'b0 : k == 1 ? levels[1] : k == 2 ? levels[0]
                : 1'b1));
        end
        // flags: write 1 keeps, write 0 clears; event status clears on read
        @(posedge i_sys_clk) i_comp_event <= 4'hf;
        @(posedge i_sys_clk) i_comp_event <= 4'h0;
        apb(CSH_ADR_STATUS, 1'b1, 32'ha0);
        apb(CSH_ADR_STATUS, 1'b0, 0);
        chk(rd, {24'h0, 4'ha, levels[6:3]});
        chk(32'(o_irq), 32'h0);
        apb(CSH_ADR_EVT_MASK, 1'b1, 32'h01);
        chk(32'(o_irq), 32'h1);
        apb(CSH_ADR_EVT_STAT, 1'b0, 0);
        chk(rd, 32'h0f);
        chk(32'(o_irq), 32'h0);
        apb(CSH_ADR_HALL, 1'b1, 32'h40);
        @(posedge i_sys_clk) i_hall_grp0 <= 3'b101;
        i_hall_grp1 <= 3'b111;
        repeat (4) @(posedge i_sys_clk);
        apb(CSH_ADR_HALL, 1'b0, 0);
        chk(rd, 32'hc5);
        chk(32'(o_hall_irq), 32'h1);
        apb(CSH_ADR_HALL, 1'b1, 32'h40);
        chk(32'(o_hall_irq), 32'h0);
        apb(CSH_ADR_SWITCH, 1'b1, 32'h16);
        chk(32'({o_bus_current_switch, o_comp3_single_input, o_scale_up_enable,
            o_comp12_function_switch}), 32'he);
        apb(CSH_ADR_SWITCH, 1'b1, 32'h09);
        chk(32'({o_comp5_hysteresis, o_comp5_enable, o_bus_current_switch}), 32'h6);
        apb(CSH_ADR_SWITCH, 1'b1, 32'h16);
        @(posedge i_sys_clk) i_comparator_input_mode <= CSH_MODE_RESISTOR;
        @(negedge i_sys_clk) chk(32'(o_comp12_function_switch), 32'h1);
        win(2'b01, 8'h21, 1'b0, 1'b0);
        win(2'b01, 8'h21, 1'b0, 1'b1);
        win(2'b10, 8'h21, 1'b0, 1'b1);
        win(2'b11, 8'h21, 1'b0, 1'b0);
        win(2'b11, 8'h21, 1'b0, 1'b1);
        win(2'b00, 8'h21, 1'b0, 1'b1);
        win(2'b01, 8'h10, 1'b1, 1'b0);
        conclude();
    end
endmodule
`default_nettype wire
